// ---- core/rbw_pkg.sv ----
//====================
// Overview of operation
// R1: host toggles the heartbeat channel on a three-second cycle while alive
// R2: heartbeat steady on or off for thirty seconds forces all valves and heaters off
// R3: decode I2C write commands and set each relay and switch output accordingly
// R4: power-up hold keeps outputs, ports and I2C fixed until host takes control; the I2C engine here is held idle only until the supply settles
// R5: sixteen status indicators, one per channel, lit when the channel is energised
// R6: cell heater channel energised heats the reaction cell, default not heating
// R7: converter heater channel heats only when span gas generator option is fitted
// R8: zero/span valve energised routes span gas, default routes zero gas
// R9: sample/cal valve energised passes calibration gas, default passes sample gas
// R10: autozero valve energised bypasses reaction cell, default routes to cell
// R11: converter path valve energised passes gas through converter, default bypasses
// R12: dual span valve energised selects span inlet one, else inlet two; option only
// R13: span shutoff energised stops span gas, default open; pressurized span option only
// R14: zero shutoff energised stops zero gas, default open; pressurized zero option only
// R15: valves form two driver groups of at most four valves each
// R16: heaters switch only through their relay channel on host command
// R17: after a trip stay off until heartbeat resumes and host rewrites commands
//====================
package rbw_pkg;

    // ====================
    // timing
    localparam longint CLK_HZ = 25_000_000;
    localparam longint HB_TIMEOUT_S = 30;
    localparam longint HB_TIMEOUT_CYC = HB_TIMEOUT_S * CLK_HZ;
    localparam longint POR_TIME_MS = 100;
    localparam longint POR_CYC = (POR_TIME_MS * CLK_HZ) / 1000;

    // ====================
    // I2C register indices
    localparam logic [7:0] REG_CMD_LO = 8'h00;
    localparam logic [7:0] REG_CMD_HI = 8'h01;
    localparam logic [7:0] REG_CONTROL = 8'h02;
    localparam logic [7:0] REG_STATUS = 8'h03;
    localparam logic [6:0] I2C_ADDR_DEFAULT = 7'h20;

    // ====================
    // channel positions in the command word
    localparam int CH_HEARTBEAT = 0;
    localparam int CH_CELL_HEATER = 1;
    localparam int CH_AUX_HEATER = 2;
    localparam int CH_CONV_HEATER = 4;
    localparam int CH_ZERO_SPAN = 6;
    localparam int CH_SAMPLE_CAL = 7;
    localparam int CH_AUTOZERO = 8;
    localparam int CH_CONV_PATH = 9;
    localparam int CH_DUAL_SPAN = 10;
    localparam int CH_SPAN_SHUTOFF = 11;
    localparam int CH_ZERO_SHUTOFF = 12;
    localparam int VALVE_GRP_A_LSB = 6;
    localparam int VALVE_GRP_B_LSB = 10;
    localparam int VALVES_PER_GRP = 4;
    localparam int NUM_CHANNELS = 16;
    localparam logic [15:0] CMD_RESET = 16'h0000;
    localparam logic [15:0] HB_ONLY_MASK = 16'h0001;

    // ====================
    // control and status bit positions
    localparam int CTL_TAKE_BIT = 0;
    localparam int STS_TRIP_BIT = 0;
    localparam int STS_HOLD_BIT = 1;
    localparam int STS_HB_RESUMED_BIT = 2;

    // ====================
    // state encodings
    typedef enum logic [2:0] {
        I2C_IDLE, I2C_ADDR, I2C_INDEX, I2C_WDATA, I2C_RDATA, I2C_RACK
    } rbw_i2c_state_t;

    typedef enum logic [1:0] {
        PU_WAIT_SUPPLY, PU_WAIT_HOST, PU_RUN
    } rbw_pu_state_t;

endpackage

// ---- core/rbw_link_if.sv ----
`timescale 1ns/1ps
// ====================
// line events and watchdog handshake between the core and its helpers
interface rbw_link_if;
    logic sclRise;
    logic sclFall;
    logic startSeen;
    logic stopSeen;
    logic sdaLevel;
    logic hbLevel;
    logic wdArm;
    logic wdTrip;
    logic hbToggled;

    modport mon (output sclRise, sclFall, startSeen, stopSeen, sdaLevel);
    modport wd (input hbLevel, wdArm, output wdTrip, hbToggled);
    modport core (input sclRise, sclFall, startSeen, stopSeen, sdaLevel, wdTrip, hbToggled,
                  output hbLevel, wdArm);
endinterface

// ---- core/rbw_line_monitor.sv ----
`timescale 1ns/1ps
// ====================
// turns the sampled I2C lines into edge and start/stop events
module rbw_line_monitor
    import rbw_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic sclIn,
    input wire logic sdaIn,
    rbw_link_if.mon lnk
);
    typedef struct packed {
        logic scl;
        logic sda;
        logic sclPrev;
        logic sdaPrev;
    } rbw_mon_st_t;

    rbw_mon_st_t st;
    rbw_mon_st_t next_st;

    // shift the line history
    always_comb begin
        next_st = st;
        next_st.scl = sclIn;
        next_st.sda = sdaIn;
        next_st.sclPrev = st.scl;
        next_st.sdaPrev = st.sda;
    end

    // idle bus is high on both lines
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            st <= '1;
        end else begin
            st <= next_st;
        end
    end

    // events seen between the two history stages
    assign lnk.sclRise = st.scl & ~st.sclPrev;
    assign lnk.sclFall = ~st.scl & st.sclPrev;
    assign lnk.startSeen = st.scl & st.sclPrev & st.sdaPrev & ~st.sda;
    assign lnk.stopSeen = st.scl & st.sclPrev & ~st.sdaPrev & st.sda;
    assign lnk.sdaLevel = st.sda;
endmodule

// ---- core/rbw_hb_watchdog.sv ----
`timescale 1ns/1ps
// ====================
// measures how long the heartbeat channel has stood still
module rbw_hb_watchdog
    import rbw_pkg::*;
#(
    parameter longint TimeoutCycles = HB_TIMEOUT_CYC
) (
    input wire logic core_clk,
    input wire logic rst_b,
    rbw_link_if.wd lnk
);
    localparam logic [31:0] LIMIT = 32'(TimeoutCycles);

    typedef struct packed {
        logic prevHb;
        logic [31:0] count;
        logic trip;
        logic toggled;
    } rbw_wd_st_t;

    rbw_wd_st_t st;
    rbw_wd_st_t next_st;

    // count still cycles, fire one trip pulse at the limit
    always_comb begin
        next_st = st;
        next_st.trip = 1'h0;
        next_st.toggled = 1'h0;
        next_st.prevHb = lnk.hbLevel;
        if (lnk.hbLevel != st.prevHb) begin
            next_st.count = '0;
            next_st.toggled = 1'h1; // see R1
        end else if (!lnk.wdArm) begin
            next_st.count = '0;
        end else if (st.count < LIMIT - 32'h0000_0001) begin
            next_st.count = st.count + 32'h0000_0001;
        end else if (st.count == LIMIT - 32'h0000_0001) begin
            next_st.trip = 1'h1; // see R2
            next_st.count = LIMIT;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign lnk.wdTrip = st.trip;
    assign lnk.hbToggled = st.toggled;
endmodule

// ---- core/rbw_relay_ctrl.sv ----
`timescale 1ns/1ps
// ====================
// relay board output controller: I2C slave, power-up hold, watchdog safe state
module rbw_relay_ctrl
    import rbw_pkg::*;
#(
    parameter logic [6:0] I2cAddr = I2C_ADDR_DEFAULT,
    parameter longint HbTimeoutCycles = HB_TIMEOUT_CYC,
    parameter longint PorCycles = POR_CYC
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic supplyOk,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    input wire logic optSpanGen,
    input wire logic optDualSpan,
    input wire logic optPressSpan,
    input wire logic optPressZero,
    output logic [15:0] statusLed,
    output logic cellHeaterOn,
    output logic auxHeaterOn,
    output logic converterHeaterOn,
    output logic [3:0] valveGroupA,
    output logic [3:0] valveGroupB,
    output logic powerUpHold,
    output logic watchdogTripped
);
    localparam logic [31:0] POR_LAST = 32'(PorCycles - 1);
    localparam logic [3:0] BYTE_BITS = 4'h8;

    typedef struct packed {
        rbw_pu_state_t pu;
        logic [31:0] porCnt;
        rbw_i2c_state_t i2c;
        logic [3:0] bitCnt;
        logic [7:0] shift;
        logic [7:0] index;
        logic handover;
        logic sdaOe;
        logic sdaOut;
        logic [15:0] cmd;
        logic tripped;
        logic hbResumed;
        logic [15:0] led;
        logic [2:0] heater;
        logic [3:0] valveA;
        logic [3:0] valveB;
        logic hold;
    } rbw_core_st_t;

    rbw_core_st_t st;
    rbw_core_st_t next_st;
    rbw_link_if lnk();

    // ====================
    // helpers
    rbw_line_monitor u_mon (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .sclIn(sclIn),
        .sdaIn(sdaIn),
        .lnk(lnk)
    );

    rbw_hb_watchdog #(
        .TimeoutCycles(HbTimeoutCycles)
    ) u_wd (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .lnk(lnk)
    );

    // heartbeat level and arming seen by the watchdog
    assign lnk.hbLevel = st.cmd[CH_HEARTBEAT];
    assign lnk.wdArm = (st.pu == PU_RUN);

    // ====================
    // register read decode
    function automatic logic [7:0] readReg(input rbw_core_st_t s, input logic [7:0] idx);
        logic [7:0] val;
        val = 8'h00;
        if (idx == REG_CMD_LO) begin
            val = s.cmd[7:0];
        end else if (idx == REG_CMD_HI) begin
            val = s.cmd[15:8];
        end else if (idx == REG_CONTROL) begin
            val[CTL_TAKE_BIT] = (s.pu == PU_RUN);
        end else if (idx == REG_STATUS) begin
            val[STS_TRIP_BIT] = s.tripped;
            val[STS_HOLD_BIT] = s.hold;
            val[STS_HB_RESUMED_BIT] = s.hbResumed;
        end
        return val;
    endfunction

    // ====================
    // next-state logic
    always_comb begin
        logic wrEn;
        logic [7:0] wrIdx;
        logic [7:0] wrData;
        logic [15:0] eff;
        wrEn = 1'h0;
        wrIdx = 8'h00;
        wrData = 8'h00;
        eff = CMD_RESET;
        next_st = st;
        next_st.sdaOut = 1'h0;

        // power-up supervisor
        case (st.pu)
            PU_WAIT_SUPPLY: begin
                if (!supplyOk) begin
                    next_st.porCnt = '0;
                end else if (st.porCnt >= POR_LAST) begin
                    next_st.pu = PU_WAIT_HOST;
                    next_st.porCnt = '0;
                end else begin
                    next_st.porCnt = st.porCnt + 32'h0000_0001;
                end
            end
            default: begin
            end
        endcase

        // I2C byte engine, alive once the supply has settled
        if (st.pu == PU_WAIT_SUPPLY) begin
            next_st.i2c = I2C_IDLE; // see R4
            next_st.sdaOe = 1'h0;
            next_st.handover = 1'h0;
        end else if (lnk.startSeen) begin
            next_st.i2c = I2C_ADDR;
            next_st.bitCnt = '0;
            next_st.sdaOe = 1'h0;
            next_st.handover = 1'h0;
        end else if (lnk.stopSeen) begin
            next_st.i2c = I2C_IDLE;
            next_st.sdaOe = 1'h0;
            next_st.handover = 1'h0;
        end else if (lnk.sclRise) begin
            case (st.i2c)
                I2C_ADDR, I2C_INDEX, I2C_WDATA: begin
                    if (!st.handover) begin
                        next_st.shift = {st.shift[6:0], lnk.sdaLevel};
                        next_st.bitCnt = st.bitCnt + 4'h1;
                    end
                end
                I2C_RDATA: begin
                    if (!st.handover) begin
                        next_st.bitCnt = st.bitCnt + 4'h1;
                    end
                end
                I2C_RACK: begin
                    if (!lnk.sdaLevel) begin
                        next_st.i2c = I2C_RDATA;
                        next_st.index = st.index + 8'h01;
                        next_st.handover = 1'h1;
                    end else begin
                        next_st.i2c = I2C_IDLE;
                    end
                end
                default: begin
                end
            endcase
        end else if (lnk.sclFall) begin
            if (st.handover) begin
                // end of acknowledge slot, first read bit goes out here
                next_st.handover = 1'h0;
                next_st.sdaOe = 1'h0;
                next_st.bitCnt = '0;
                if (st.i2c == I2C_RDATA) begin
                    next_st.shift = readReg(st, st.index);
                    next_st.sdaOe = ~next_st.shift[7];
                end
            end else if (st.bitCnt == BYTE_BITS) begin
                next_st.bitCnt = '0;
                case (st.i2c)
                    I2C_ADDR: begin
                        if (st.shift[7:1] == I2cAddr) begin
                            next_st.handover = 1'h1;
                            next_st.sdaOe = 1'h1;
                            next_st.i2c = st.shift[0] ? I2C_RDATA : I2C_INDEX;
                        end else begin
                            next_st.i2c = I2C_IDLE;
                        end
                    end
                    I2C_INDEX: begin
                        next_st.index = st.shift;
                        next_st.handover = 1'h1;
                        next_st.sdaOe = 1'h1;
                        next_st.i2c = I2C_WDATA;
                    end
                    I2C_WDATA: begin
                        wrEn = 1'h1; // see R3
                        wrIdx = st.index;
                        wrData = st.shift;
                        next_st.index = st.index + 8'h01;
                        next_st.handover = 1'h1;
                        next_st.sdaOe = 1'h1;
                    end
                    I2C_RDATA: begin
                        next_st.sdaOe = 1'h0;
                        next_st.i2c = I2C_RACK;
                    end
                    default: begin
                    end
                endcase
            end else if (st.i2c == I2C_RDATA) begin
                next_st.shift = {st.shift[6:0], 1'h0};
                next_st.sdaOe = ~st.shift[6];
            end
        end

        // register writes
        if (wrEn) begin
            if (wrIdx == REG_CMD_LO) begin
                next_st.cmd[7:0] = wrData; // see R3
            end else if (wrIdx == REG_CMD_HI) begin
                next_st.cmd[15:8] = wrData; // see R3
            end else if (wrIdx == REG_CONTROL) begin
                if (wrData[CTL_TAKE_BIT]) begin
                    next_st.pu = PU_RUN; // see R4
                end else begin
                    next_st.pu = PU_WAIT_HOST;
                end
            end
            // rewrite after resumed heartbeat re-arms the outputs
            if ((wrIdx == REG_CMD_LO || wrIdx == REG_CMD_HI) && st.tripped && st.hbResumed) begin
                next_st.tripped = 1'h0; // see R17
                next_st.hbResumed = 1'h0;
            end
        end

        // heartbeat seen again after a trip
        if (lnk.hbToggled && st.tripped) begin
            next_st.hbResumed = 1'h1; // see R17
        end

        // trip wins over a rewrite clear in the same cycle; supply loss still clears it
        if (lnk.wdTrip) begin
            next_st.tripped = 1'h1; // see R2
            next_st.hbResumed = 1'h0;
            next_st.cmd = next_st.cmd & HB_ONLY_MASK; // see R17
        end

        // supply loss returns everything to the held state
        if (!supplyOk && st.pu != PU_WAIT_SUPPLY) begin
            next_st.pu = PU_WAIT_SUPPLY;
            next_st.porCnt = '0;
            next_st.cmd = CMD_RESET;
            next_st.tripped = 1'h0;
            next_st.hbResumed = 1'h0;
        end

        // effective channel states
        if (st.pu != PU_RUN) begin
            eff = CMD_RESET; // see R4
        end else if (st.tripped) begin
            eff = st.cmd & HB_ONLY_MASK; // see R2
        end else begin
            eff = st.cmd;
        end
        eff[CH_CONV_HEATER] = eff[CH_CONV_HEATER] & optSpanGen; // see R7
        eff[CH_DUAL_SPAN] = eff[CH_DUAL_SPAN] & optDualSpan; // see R12
        eff[CH_SPAN_SHUTOFF] = eff[CH_SPAN_SHUTOFF] & optPressSpan; // see R13
        eff[CH_ZERO_SHUTOFF] = eff[CH_ZERO_SHUTOFF] & optPressZero; // see R14

        // indicators and drivers
        next_st.led = eff; // see R5
        next_st.heater = {eff[CH_CONV_HEATER], eff[CH_AUX_HEATER], eff[CH_CELL_HEATER]}; // see R16
        next_st.valveA = eff[VALVE_GRP_A_LSB +: VALVES_PER_GRP]; // see R15
        next_st.valveB = eff[VALVE_GRP_B_LSB +: VALVES_PER_GRP]; // see R15
        next_st.hold = (next_st.pu != PU_RUN);
    end

    // ====================
    // state register
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            st <= '0;
            st.hold <= 1'h1;
        end else begin
            st <= next_st;
        end
    end

    // ====================
    // outputs, all straight from the state register
    assign sdaOut = st.sdaOut;
    assign sdaOe = st.sdaOe;
    assign statusLed = st.led;
    assign cellHeaterOn = st.heater[0]; // see R6
    assign auxHeaterOn = st.heater[1];
    assign converterHeaterOn = st.heater[2]; // see R7
    // group A: zero/span, sample/cal, autozero, measurement path select
    assign valveGroupA = st.valveA; // see R8 R9 R10 R11
    // group B: dual span, span shutoff, zero shutoff, spare
    assign valveGroupB = st.valveB; // see R12
    assign powerUpHold = st.hold;
    assign watchdogTripped = st.tripped;
endmodule

// ---- verif/rbw_relay_monitor.sv ----
`timescale 1ns/1ps
// ====================
// port checks on the relay controller
module rbw_relay_monitor
    import rbw_pkg::*;
#(
    parameter longint HbTimeoutCycles = HB_TIMEOUT_CYC,
    parameter longint PorCycles = POR_CYC
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic supplyOk,
    input wire logic sdaOut,
    input wire logic optSpanGen,
    input wire logic optDualSpan,
    input wire logic optPressSpan,
    input wire logic optPressZero,
    input wire logic [15:0] statusLed,
    input wire logic cellHeaterOn,
    input wire logic auxHeaterOn,
    input wire logic converterHeaterOn,
    input wire logic [3:0] valveGroupA,
    input wire logic [3:0] valveGroupB,
    input wire logic powerUpHold,
    input wire logic watchdogTripped
);
    longint hbCnt;
    longint supCnt;
    logic prevHb;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    // cycles the heartbeat has stood still, cycles of good supply
    always_ff @(posedge core_clk) begin
        prevHb <= statusLed[CH_HEARTBEAT];
        if (!rst_b || powerUpHold || statusLed[CH_HEARTBEAT] != prevHb) begin
            hbCnt <= 0;
        end else begin
            hbCnt <= hbCnt + 1;
        end
        if (!rst_b || !supplyOk) begin
            supCnt <= 0;
        end else if (supCnt <= PorCycles) begin
            supCnt <= supCnt + 1;
        end
    end

    hold_outputs_off_a: assert property (
        powerUpHold && $past(powerUpHold) |-> statusLed == 16'h0000 && !cellHeaterOn
        && !auxHeaterOn && !converterHeaterOn && valveGroupA == 4'h0 && valveGroupB == 4'h0)
        else $error("outputs on during hold");
    hold_release_a: assert property (
        $fell(powerUpHold) |-> supCnt >= PorCycles) else $error("hold left too early");
    heater_led_a: assert property (
        cellHeaterOn == statusLed[CH_CELL_HEATER] && auxHeaterOn == statusLed[CH_AUX_HEATER]
        && converterHeaterOn == statusLed[CH_CONV_HEATER]) else $error("heater led differs");
    valve_led_a: assert property (
        valveGroupA == statusLed[VALVE_GRP_A_LSB +: VALVES_PER_GRP]
        && valveGroupB == statusLed[VALVE_GRP_B_LSB +: VALVES_PER_GRP])
        else $error("valve led differs");
    gen_gate_a: assert property (
        !optSpanGen && !$past(optSpanGen) |-> !statusLed[CH_CONV_HEATER])
        else $error("converter heater without option");
    press_gate_a: assert property (
        (!optDualSpan && !$past(optDualSpan) |-> !statusLed[CH_DUAL_SPAN])
        and (!optPressSpan && !$past(optPressSpan) |-> !statusLed[CH_SPAN_SHUTOFF])
        and (!optPressZero && !$past(optPressZero) |-> !statusLed[CH_ZERO_SHUTOFF]))
        else $error("option channel without option");
    trip_outputs_a: assert property (
        watchdogTripped && $past(watchdogTripped) |-> statusLed[15:1] == 15'h0000)
        else $error("outputs on after trip");
    trip_late_a: assert property (
        $rose(watchdogTripped) |-> hbCnt + 4 >= HbTimeoutCycles) else $error("early trip");
    trip_prompt_a: assert property (
        !watchdogTripped && !powerUpHold |-> hbCnt <= HbTimeoutCycles + 4)
        else $error("missed trip");
    sda_open_drain_a: assert property (!sdaOut) else $error("sda driven high");
endmodule

// ---- verif/rbw_host_model.sv ----
`timescale 1ns/1ps
// ====================
// host side of the link: bit-banged master, SDA pulled up
module rbw_host_model (
    input wire logic core_clk,
    input wire logic sdaWire,
    output logic sclOut,
    output logic sdaLow
);
    // idle bus: both lines released
    initial begin
        sclOut = 1'b1;
        sdaLow = 1'b0;
    end

    // whole cycles, then just past the edge
    task automatic wt(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    // one bit slot: data set two cycles after SCL falls, SCL low and high eight cycles each
    task automatic bitSlot(input logic b, output logic seen);
        wt(2);
        sdaLow = !b;
        wt(6);
        sclOut = 1'b1;
        wt(8);
        seen = sdaWire;
        sclOut = 1'b0;
    endtask

    // byte msb first, then the ack slot
    task automatic sendByte(input logic [7:0] b, inout logic ack);
        logic seen;
        for (int i = 7; i >= 0; i--) begin
            bitSlot(b[i], seen);
        end
        bitSlot(1'b1, seen);
        ack = ack && !seen;
    endtask

    // start, address, index, two data bytes, stop
    task automatic write(input logic [6:0] addr, input logic [7:0] idx,
                         input logic [15:0] data, output logic ack);
        ack = 1'b1;
        sdaLow = 1'b1;
        wt(8);
        sclOut = 1'b0;
        sendByte({addr, 1'b0}, ack);
        sendByte(idx, ack);
        sendByte(data[7:0], ack);
        sendByte(data[15:8], ack);
        wt(2);
        sdaLow = 1'b1;
        wt(6);
        sclOut = 1'b1;
        wt(8);
        sdaLow = 1'b0;
        wt(8);
    endtask
endmodule

// ---- verif/tb_top.sv ----
`timescale 1ns/1ps
// ====================
// bench top: host model, relay controller, port checks
module tb_top;
    import rbw_pkg::*;
    localparam longint TbHb = 2000;
    localparam logic [15:0] PatA = 16'h0A93;
    localparam logic [15:0] PatB = 16'h1544;
    localparam logic [15:0] AllUsed = 16'h1FD7;
    localparam logic [15:0] OptBits = 16'h1C10;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic supplyOk = 1'b0;
    logic optSpanGen = 1'b1;
    logic optDualSpan = 1'b1;
    logic optPressSpan = 1'b1;
    logic optPressZero = 1'b1;
    logic sclOut, hostSdaLow, sdaWire, sdaOut, sdaOe, ack;
    logic cellHeaterOn, auxHeaterOn, converterHeaterOn, powerUpHold, watchdogTripped;
    logic [15:0] statusLed;
    logic [3:0] valveGroupA, valveGroupB;
    int n_fail = 0;
    int checked = 0;
    int cycles = 0;

    // open-drain SDA: released means pulled high
    assign sdaWire = (sdaOe ? sdaOut : 1'b1) && !hostSdaLow;

    rbw_host_model u_rbw_host_model (.core_clk(core_clk), .sdaWire(sdaWire),
        .sclOut(sclOut), .sdaLow(hostSdaLow));
    rbw_relay_ctrl #(.HbTimeoutCycles(TbHb), .PorCycles(10)) u_rbw_relay_ctrl (
        .core_clk(core_clk), .rst_b(rst_b), .supplyOk(supplyOk), .sclIn(sclOut),
        .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe), .optSpanGen(optSpanGen),
        .optDualSpan(optDualSpan), .optPressSpan(optPressSpan), .optPressZero(optPressZero),
        .statusLed(statusLed), .cellHeaterOn(cellHeaterOn), .auxHeaterOn(auxHeaterOn),
        .converterHeaterOn(converterHeaterOn), .valveGroupA(valveGroupA),
        .valveGroupB(valveGroupB), .powerUpHold(powerUpHold),
        .watchdogTripped(watchdogTripped));

    // clock and hang limit
    always #20 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 40000) begin
            n_fail++;
            $display("mismatch at %0t: run too long", $time);
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: %s saw %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic sendCmd(input logic [15:0] d, input logic expAck);
        u_rbw_host_model.write(I2C_ADDR_DEFAULT, REG_CMD_LO, d, ack);
        check(ack, expAck, "command ack");
    endtask

    task automatic expectOut(input logic [15:0] p);
        check(statusLed, p, "leds");
        check(cellHeaterOn, p[CH_CELL_HEATER], "cell heater");
        check(auxHeaterOn, p[CH_AUX_HEATER], "aux heater");
        check(converterHeaterOn, p[CH_CONV_HEATER], "conv heater");
        check(valveGroupA, p[9:6], "valves a");
        check(valveGroupB, p[13:10], "valves b");
    endtask

    // held outputs, no answer before supply settles, takeover
    task automatic test_power_up();
        expectOut(16'h0000);
        check(powerUpHold, 1'b1, "hold at reset");
        u_rbw_host_model.write(I2C_ADDR_DEFAULT, REG_CONTROL, 16'h0001, ack);
        check(ack, 1'b0, "ack with supply low");
        supplyOk = 1'b1;
        tick(30);
        check(powerUpHold, 1'b1, "hold before takeover");
        u_rbw_host_model.write(I2C_ADDR_DEFAULT, REG_CONTROL, 16'h0001, ack);
        check(ack, 1'b1, "takeover ack");
        check(powerUpHold, 1'b0, "hold after takeover");
        $display("test power_up done");
    endtask

    // each used channel on and off; heartbeat toggles between writes
    task automatic test_channels();
        sendCmd(PatA, 1'b1);
        expectOut(PatA);
        sendCmd(PatB, 1'b1);
        expectOut(PatB);
        $display("test channels done");
    endtask

    // option channels stay off while the option is absent
    task automatic test_options();
        {optSpanGen, optDualSpan, optPressSpan, optPressZero} = 4'h0;
        sendCmd(AllUsed, 1'b1);
        expectOut(AllUsed & ~OptBits);
        {optSpanGen, optDualSpan, optPressSpan, optPressZero} = 4'hF;
        tick(3);
        expectOut(AllUsed);
        u_rbw_host_model.write(I2C_ADDR_DEFAULT ^ 7'h01, REG_CMD_LO, PatB, ack);
        check(ack, 1'b0, "foreign address ack");
        expectOut(AllUsed);
        $display("test options done");
    endtask

    // stale heartbeat trips; recovery needs a toggle then a write
    task automatic test_watchdog();
        tick(TbHb);
        check(watchdogTripped, 1'b1, "trip");
        expectOut(16'h0001);
        sendCmd(16'h0003, 1'b1);
        check(watchdogTripped, 1'b1, "trip without toggle");
        expectOut(16'h0001);
        sendCmd(16'h0002, 1'b1);
        check(watchdogTripped, 1'b0, "trip cleared");
        expectOut(16'h0002);
        $display("test watchdog done");
    endtask

    // supply loss returns to the held state
    task automatic test_supply_drop();
        supplyOk = 1'b0;
        tick(4);
        check(powerUpHold, 1'b1, "hold on supply loss");
        expectOut(16'h0000);
        $display("test supply_drop done");
    endtask

    initial begin
        tick(10);
        rst_b = 1'b1;
        tick(2);
        test_power_up();
        test_channels();
        test_options();
        test_watchdog();
        test_supply_drop();
        print_verdict();
    end
endmodule

bind rbw_relay_ctrl rbw_relay_monitor #(.HbTimeoutCycles(HbTimeoutCycles),
    .PorCycles(PorCycles)) u_rbw_relay_monitor (
    .core_clk(core_clk), .rst_b(rst_b), .supplyOk(supplyOk), .sdaOut(sdaOut),
    .optSpanGen(optSpanGen), .optDualSpan(optDualSpan),
    .optPressSpan(optPressSpan), .optPressZero(optPressZero), .statusLed(statusLed),
    .cellHeaterOn(cellHeaterOn), .auxHeaterOn(auxHeaterOn),
    .converterHeaterOn(converterHeaterOn), .valveGroupA(valveGroupA),
    .valveGroupB(valveGroupB), .powerUpHold(powerUpHold), .watchdogTripped(watchdogTripped));
